// ### core/eth_mac_defines.svh
// Register offsets, field positions, reset values and frame constants of the receive slice
`ifndef ETH_MAC_DEFINES_SVH
`define ETH_MAC_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_NET_CFG 12'h004
`define OFS_PHY_SEL 12'h00C
`define OFS_RX_STATUS 12'h010
`define OFS_FCS_ERR_CNT 12'h014
`define OFS_GAP_STRETCH 12'h018
`define OFS_CNT_256_511 12'h174

// ****************************************
// Reset values and write masks
// ****************************************
`define NET_CFG_RESET 32'h0008_0000
`define NET_CFG_WMASK 32'h77FF_F1FF
`define PHY_SEL_RESET 1'b0
`define GAP_STRETCH_RESET 12'h000

// ****************************************
// Field positions
// ****************************************
`define CFG_IGN_IDLE_ERR 30
`define CFG_BAD_PREAMBLE 29
`define CFG_GAP_STRETCH 28
`define CFG_IGN_FCS 26
`define CFG_HD_RX 25
`define CFG_FULL_DUPLEX 1
`define STAT_IDLE_ERR 0
`define STAT_LAST_FCS_BAD 1

// ****************************************
// Frame constants
// ****************************************
`define MIN_IPG_BITS 16'h0060
`define STAT_LEN_MIN 14'h0100
`define STAT_LEN_MAX 14'h01FF
`define LEN_MAX 14'h3FFF
`define PREAMBLE_NIBBLES 4'hF
`define NIB_PREAMBLE 4'h5
`define NIB_SFD 4'hD
`define PAUSE_HEADER 32'h8808_0001
`define HDR_FIRST 14'h000C
`define HDR_LAST 14'h000F
`define CRC_INIT 32'hFFFF_FFFF
`define CRC_POLY 32'hEDB8_8320
`define CRC_RESIDUE 32'hDEBB_20E3

`endif

// ### core/eth_mac_pkg.sv
// Types shared by the receive slice
`default_nettype none
package eth_mac_pkg;

	// ****************************************
	// Link pins, frame report and receive states
	// ****************************************
	typedef struct packed {
		logic clk;
		logic dv;
		logic er;
		logic [3:0] rxd;
	} phy_rx_type;

	typedef struct packed {
		logic [13:0] length;
		logic fcs_bad;
		logic preamble_bad;
		logic rx_err;
		logic pause;
		logic accepted;
	} rx_status_type;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_PRE = 4'b0010,
		ST_DATA = 4'b0100,
		ST_DROP = 4'b1000
	} rx_state_type;

endpackage
`default_nettype wire

// ### core/eth_mac_rx_config_stats.sv
// Receive acceptance, interface select, gap stretch and 256-511 byte statistics
`timescale 1ns/1ps
`default_nettype none
`include "eth_mac_defines.svh"

module eth_mac_rx_config_stats (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Register port
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// PHY receive pins
	input wire eth_mac_pkg::phy_rx_type phy_rx,
	// Receive byte stream and frame report
	output logic [7:0] rx_byte,
	output logic rx_byte_valid,
	output logic frame_end,
	output eth_mac_pkg::rx_status_type rx_status,
	// Filter and DMA copy result
	input wire logic copy_done,
	input wire logic copy_ok,
	input wire logic filter_pass,
	// Transmitter side
	input wire logic tx_active,
	input wire logic tx_frame_end,
	input wire logic [13:0] tx_frame_len,
	output logic [15:0] ipg_bits
);
	import eth_mac_pkg::*;

	// ****************************************
	// Registers
	// ****************************************
	logic [31:0] net_cfg_reg;
	logic mii_sel_reg;
	logic [11:0] stretch_reg;
	logic [31:0] fcs_err_cnt_reg;
	logic [31:0] cnt_256_511_reg;
	logic idle_err_reg;
	logic last_fcs_bad_reg;
	logic [31:0] rdata_next;

	logic ign_idle_err;
	logic accept_bad_pre;
	logic gap_en;
	logic ign_fcs;
	logic hd_rx_en;
	logic full_duplex;

	assign ign_idle_err = net_cfg_reg[`CFG_IGN_IDLE_ERR];
	assign accept_bad_pre = net_cfg_reg[`CFG_BAD_PREAMBLE];
	assign gap_en = net_cfg_reg[`CFG_GAP_STRETCH];
	assign ign_fcs = net_cfg_reg[`CFG_IGN_FCS];
	assign hd_rx_en = net_cfg_reg[`CFG_HD_RX];
	assign full_duplex = net_cfg_reg[`CFG_FULL_DUPLEX];

	always_ff @(posedge mclk) begin
		if (srst) begin
			net_cfg_reg <= `NET_CFG_RESET;
			mii_sel_reg <= `PHY_SEL_RESET;
			stretch_reg <= `GAP_STRETCH_RESET;
		end else if (reg_wr) begin
			case (reg_addr)
				`OFS_NET_CFG: net_cfg_reg <= reg_wdata & `NET_CFG_WMASK;
				`OFS_PHY_SEL: mii_sel_reg <= reg_wdata[0];
				`OFS_GAP_STRETCH: stretch_reg <= reg_wdata[11:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		rdata_next = 32'h0000_0000;
		case (reg_addr)
			`OFS_NET_CFG: rdata_next = net_cfg_reg;
			`OFS_PHY_SEL: rdata_next = {31'h0000_0000, mii_sel_reg};
			`OFS_RX_STATUS: rdata_next = {30'h0000_0000, last_fcs_bad_reg, idle_err_reg};
			`OFS_FCS_ERR_CNT: rdata_next = fcs_err_cnt_reg;
			`OFS_GAP_STRETCH: rdata_next = {20'h0_0000, stretch_reg};
			`OFS_CNT_256_511: rdata_next = cnt_256_511_reg;
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	// Data only in the cycle after the read strobe
	always_ff @(posedge mclk) begin
		if (srst) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= reg_rd ? rdata_next : 32'h0000_0000;
		end
	end

	// ****************************************
	// Pin synchroniser and link clock edge
	// ****************************************
	phy_rx_type rx_s1;
	phy_rx_type rx_s2;
	logic clk_s3;
	logic dv_s3;
	logic clk_rise;
	logic dv_fall;
	logic err_eff;

	always_ff @(posedge mclk) begin
		if (srst) begin
			rx_s1 <= '0;
			rx_s2 <= '0;
			clk_s3 <= 1'b0;
			dv_s3 <= 1'b0;
		end else begin
			rx_s1 <= phy_rx;
			rx_s2 <= rx_s1;
			clk_s3 <= rx_s2.clk;
			dv_s3 <= rx_s2.dv;
		end
	end

	assign clk_rise = rx_s2.clk & ~clk_s3;
	assign dv_fall = ~rx_s2.dv & dv_s3;
	// Outside a frame the error pin only counts when not ignored
	assign err_eff = rx_s2.er & (rx_s2.dv | ~ign_idle_err);

	// ****************************************
	// Nibble assembly
	// ****************************************
	// RMII dibits pair low first; only the 10 Mb/s rate is reachable at this sample clock
	logic half_reg;
	logic [1:0] lo_dibit_reg;
	logic [3:0] nib_reg;
	logic nib_valid;

	always_ff @(posedge mclk) begin
		if (srst) begin
			half_reg <= 1'b0;
			lo_dibit_reg <= 2'b00;
			nib_reg <= 4'h0;
			nib_valid <= 1'b0;
		end else begin
			nib_valid <= 1'b0;
			if (clk_rise) begin
				if (!rx_s2.dv) begin
					half_reg <= 1'b0;
				end else if (mii_sel_reg) begin
					nib_reg <= rx_s2.rxd;
					nib_valid <= 1'b1;
				end else if (!half_reg) begin
					lo_dibit_reg <= rx_s2.rxd[1:0];
					half_reg <= 1'b1;
				end else begin
					nib_reg <= {rx_s2.rxd[1:0], lo_dibit_reg};
					nib_valid <= 1'b1;
					half_reg <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// Frame state machine
	// ****************************************
	rx_state_type state_reg;
	logic [3:0] pre_cnt_reg;
	logic pre_bad_reg;
	logic frame_err_reg;
	logic carrier_err_reg;
	logic blocked_reg;
	logic nib_phase_reg;
	logic [3:0] lo_nib_reg;
	logic [13:0] len_reg;
	logic [31:0] hdr_reg;
	logic [31:0] crc_value;
	logic crc_start;
	logic tx_blocks;
	logic fcs_bad;
	logic pre_bad_now;

	assign tx_blocks = ~full_duplex & tx_active & ~hd_rx_en;
	assign fcs_bad = crc_value != `CRC_RESIDUE;
	assign pre_bad_now = pre_bad_reg | (pre_cnt_reg != `PREAMBLE_NIBBLES);
	assign crc_start = (state_reg == ST_IDLE);

	always_ff @(posedge mclk) begin
		if (srst) begin
			state_reg <= ST_IDLE;
			pre_cnt_reg <= 4'h0;
			pre_bad_reg <= 1'b0;
			frame_err_reg <= 1'b0;
			blocked_reg <= 1'b0;
			nib_phase_reg <= 1'b0;
			lo_nib_reg <= 4'h0;
			len_reg <= 14'h0000;
			hdr_reg <= 32'h0000_0000;
			rx_byte <= 8'h00;
			rx_byte_valid <= 1'b0;
			frame_end <= 1'b0;
			rx_status <= '0;
		end else begin
			rx_byte_valid <= 1'b0;
			frame_end <= 1'b0;
			if (rx_s2.dv && err_eff) begin
				frame_err_reg <= 1'b1;
			end
			if (tx_blocks && state_reg != ST_IDLE) begin
				blocked_reg <= 1'b1;
			end
			case (state_reg)
				ST_IDLE: begin
					if (rx_s2.dv) begin
						state_reg <= ST_PRE;
						pre_cnt_reg <= 4'h0;
						pre_bad_reg <= 1'b0;
						frame_err_reg <= carrier_err_reg | err_eff;
						blocked_reg <= tx_blocks;
						nib_phase_reg <= 1'b0;
						len_reg <= 14'h0000;
						hdr_reg <= 32'h0000_0000;
					end
				end
				ST_PRE: begin
					if (dv_fall) begin
						state_reg <= ST_IDLE;
					end else if (nib_valid && nib_reg == `NIB_SFD) begin
						if ((pre_bad_now && !accept_bad_pre) || blocked_reg || tx_blocks) begin
							state_reg <= ST_DROP;
						end else begin
							state_reg <= ST_DATA;
							pre_bad_reg <= pre_bad_now;
						end
					end else if (nib_valid) begin
						if (nib_reg != `NIB_PREAMBLE) begin
							pre_bad_reg <= 1'b1;
						end
						if (pre_cnt_reg != 4'hF) begin
							pre_cnt_reg <= pre_cnt_reg + 4'h1;
						end
					end
				end
				ST_DATA: begin
					if (dv_fall) begin
						state_reg <= ST_IDLE;
						frame_end <= 1'b1;
						rx_status.length <= len_reg;
						rx_status.fcs_bad <= fcs_bad;
						rx_status.preamble_bad <= pre_bad_reg;
						rx_status.rx_err <= frame_err_reg;
						rx_status.pause <= (len_reg > `HDR_LAST) && (hdr_reg == `PAUSE_HEADER);
						// Bad CRC frames kept only when software asks for it
						rx_status.accepted <= ~blocked_reg & ~frame_err_reg &
							(~fcs_bad | ign_fcs);
					end else if (nib_valid) begin
						if (!nib_phase_reg) begin
							lo_nib_reg <= nib_reg;
							nib_phase_reg <= 1'b1;
						end else begin
							nib_phase_reg <= 1'b0;
							rx_byte <= {nib_reg, lo_nib_reg};
							rx_byte_valid <= 1'b1;
							if (len_reg != `LEN_MAX) begin
								len_reg <= len_reg + 14'h0001;
							end
							if (len_reg >= `HDR_FIRST && len_reg <= `HDR_LAST) begin
								hdr_reg <= {hdr_reg[23:0], nib_reg, lo_nib_reg};
							end
						end
					end
				end
				ST_DROP: begin
					if (!rx_s2.dv) begin
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	rx_crc32 u_crc (
		.mclk(mclk),
		.srst(srst),
		.start(crc_start),
		.byte_valid(rx_byte_valid),
		.byte_data(rx_byte),
		.crc_value(crc_value)
	);

	// ****************************************
	// Status and error statistics
	// ****************************************
	// Error with data valid low spoils the next frame too
	always_ff @(posedge mclk) begin
		if (srst) begin
			idle_err_reg <= 1'b0;
			carrier_err_reg <= 1'b0;
		end else begin
			if (!rx_s2.dv && err_eff) begin
				idle_err_reg <= 1'b1;
				carrier_err_reg <= 1'b1;
			end else begin
				if (reg_wr && reg_addr == `OFS_RX_STATUS && reg_wdata[`STAT_IDLE_ERR]) begin
					idle_err_reg <= 1'b0;
				end
				if (state_reg == ST_PRE) begin
					carrier_err_reg <= 1'b0;
				end
			end
		end
	end

	// Counted whether or not the bad frame was kept
	always_ff @(posedge mclk) begin
		if (srst) begin
			fcs_err_cnt_reg <= 32'h0000_0000;
			last_fcs_bad_reg <= 1'b0;
		end else if (frame_end) begin
			last_fcs_bad_reg <= rx_status.fcs_bad;
			if (rx_status.fcs_bad) begin
				fcs_err_cnt_reg <= fcs_err_cnt_reg + 32'h0000_0001;
			end
		end
	end

	// ****************************************
	// 256 to 511 byte counter
	// ****************************************
	logic pend_reg;
	logic stat_hit;

	assign stat_hit = rx_status.accepted & ~rx_status.fcs_bad & ~rx_status.rx_err &
		~rx_status.pause & (rx_status.length >= `STAT_LEN_MIN) &
		(rx_status.length <= `STAT_LEN_MAX);

	always_ff @(posedge mclk) begin
		if (srst) begin
			pend_reg <= 1'b0;
			cnt_256_511_reg <= 32'h0000_0000;
		end else begin
			if (copy_done && pend_reg && copy_ok && filter_pass) begin
				cnt_256_511_reg <= cnt_256_511_reg + 32'h0000_0001;
			end
			if (frame_end) begin
				pend_reg <= stat_hit;
			end else if (copy_done) begin
				pend_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// Transmit gap stretch
	// ****************************************
	// Gap is length times multiplier, shifted right, never under the minimum
	logic [21:0] stretch_prod;
	logic [21:0] stretch_bits;

	assign stretch_prod = tx_frame_len * stretch_reg[7:0];
	assign stretch_bits = stretch_prod >> stretch_reg[11:8];

	always_ff @(posedge mclk) begin
		if (srst) begin
			ipg_bits <= `MIN_IPG_BITS;
		end else if (tx_frame_end) begin
			if (!gap_en || stretch_bits[15:0] < `MIN_IPG_BITS && stretch_bits[21:16] == 6'h00) begin
				ipg_bits <= `MIN_IPG_BITS;
			end else if (stretch_bits[21:16] != 6'h00) begin
				ipg_bits <= 16'hFFFF;
			end else begin
				ipg_bits <= stretch_bits[15:0];
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	property p_idle_err_ignored;
		ign_idle_err && !rx_s2.dv && !idle_err_reg && !reg_wr |=> !idle_err_reg;
	endproperty
	a_idle_err_ignored: assert property (p_idle_err_ignored) else $error("idle error not ignored");

	property p_idle_err_seen;
		!ign_idle_err && !rx_s2.dv && rx_s2.er |=> idle_err_reg;
	endproperty
	a_idle_err_seen: assert property (p_idle_err_seen) else $error("idle error lost");

	property p_bad_preamble_drop;
		state_reg == ST_PRE && nib_valid && nib_reg == `NIB_SFD && !dv_fall &&
			pre_bad_now && !accept_bad_pre |=> state_reg == ST_DROP;
	endproperty
	a_bad_preamble_drop: assert property (p_bad_preamble_drop) else $error("bad preamble kept");

	property p_gap_plain;
		tx_frame_end && !gap_en |=> ipg_bits == `MIN_IPG_BITS;
	endproperty
	a_gap_plain: assert property (p_gap_plain) else $error("gap stretched while off");

	property p_gap_floor;
		ipg_bits >= `MIN_IPG_BITS;
	endproperty
	a_gap_floor: assert property (p_gap_floor) else $error("gap under minimum");

	property p_fcs_discard;
		frame_end && rx_status.fcs_bad && !$past(ign_fcs) |-> !rx_status.accepted;
	endproperty
	a_fcs_discard: assert property (p_fcs_discard) else $error("bad crc frame kept");

	property p_fcs_keep;
		frame_end && rx_status.fcs_bad && $past(ign_fcs) && !rx_status.rx_err &&
			!$past(blocked_reg) |-> rx_status.accepted;
	endproperty
	a_fcs_keep: assert property (p_fcs_keep) else $error("bad crc frame dropped");

	property p_fcs_count;
		frame_end && rx_status.fcs_bad |=> fcs_err_cnt_reg == $past(fcs_err_cnt_reg) + 32'h0000_0001;
	endproperty
	a_fcs_count: assert property (p_fcs_count) else $error("crc error not counted");

	property p_rmii_pairs;
		nib_valid && !$past(mii_sel_reg) |-> $past(half_reg);
	endproperty
	a_rmii_pairs: assert property (p_rmii_pairs) else $error("rmii nibble from one dibit");

	property p_count_cause;
		cnt_256_511_reg != $past(cnt_256_511_reg) |->
			$past(copy_done) && $past(pend_reg) && $past(copy_ok) && $past(filter_pass);
	endproperty
	a_count_cause: assert property (p_count_cause) else $error("counter moved without cause");

	property p_pause_skip;
		frame_end && rx_status.pause |=> !pend_reg;
	endproperty
	a_pause_skip: assert property (p_pause_skip) else $error("pause frame pending count");

	c_frame_kept: cover property (frame_end && rx_status.accepted);
	c_fcs_bad: cover property (frame_end && rx_status.fcs_bad);
	c_count_up: cover property (copy_done && pend_reg && copy_ok && filter_pass);
	c_rmii_nib: cover property (nib_valid && !mii_sel_reg);

endmodule // eth_mac_rx_config_stats
`default_nettype wire

// ### core/rx_crc32.sv
// Byte-wide running CRC-32 over a received frame
`timescale 1ns/1ps
`default_nettype none
`include "eth_mac_defines.svh"

module rx_crc32 (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Byte stream
	input wire logic start,
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	// Running value
	output logic [31:0] crc_value
);

	logic [31:0] crc_next;

	always_comb begin
		crc_next = crc_value ^ {24'h00_0000, byte_data};
		for (int i = 0; i < 8; i++) begin
			crc_next = crc_next[0] ? ((crc_next >> 1) ^ `CRC_POLY) : (crc_next >> 1);
		end
	end

	always_ff @(posedge mclk) begin
		if (srst || start) begin
			crc_value <= `CRC_INIT;
		end else if (byte_valid) begin
			crc_value <= crc_next;
		end
	end

endmodule // rx_crc32
`default_nettype wire

// ### tb/eth_mac_rx_config_stats_tb_top.sv
// Self-checking bench for the receive configuration and statistics slice
`timescale 1ns/1ps
`default_nettype none
`include "eth_mac_defines.svh"

module eth_mac_rx_config_stats_tb_top;
	import eth_mac_pkg::*;

	localparam logic [31:0] CFG = 32'h0008_0002;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic [11:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic reg_wr = 1'b0, reg_rd = 1'b0, copy_done = 1'b0, copy_ok = 1'b0;
	logic filter_pass = 1'b0, tx_active = 1'b0, tx_frame_end = 1'b0;
	logic [13:0] tx_frame_len = '0;
	logic [31:0] reg_rdata, rv;
	logic [7:0] rx_byte, lastb;
	logic rx_byte_valid, frame_end;
	logic [15:0] ipg_bits;
	phy_rx_type phy_rx;
	rx_status_type rx_status, st;
	logic [7:0] frm[$];
	int fails = 0, checked = 0, fe_count = 0, nbytes = 0, cnt = 0;

	always #12.5 mclk = ~mclk;

	eth_mac_rx_config_stats dut (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.phy_rx(phy_rx), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
		.frame_end(frame_end), .rx_status(rx_status), .copy_done(copy_done),
		.copy_ok(copy_ok), .filter_pass(filter_pass), .tx_active(tx_active),
		.tx_frame_end(tx_frame_end), .tx_frame_len(tx_frame_len), .ipg_bits(ipg_bits));

	phy_link_model phy (.phy_rx(phy_rx));

	always @(posedge mclk) begin
		if (rx_byte_valid === 1'b1) begin
			nbytes++;
			lastb = rx_byte;
		end
		if (frame_end === 1'b1) begin
			fe_count++;
			st = rx_status;
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task final_report;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task rdchk(input logic [11:0] a, input logic [31:0] e);
		rd(a, rv);
		chk(rv, e, "register read");
	endtask

	// Payload is a counting pattern, so no pause header unless asked
	task automatic build(input int n, input logic pse, input logic bad);
		logic [31:0] c;
		frm = {};
		for (int i = 0; i < n; i++) frm.push_back(i[7:0]);
		if (pse) begin
			frm[12] = 8'h88;
			frm[13] = 8'h08;
			frm[14] = 8'h00;
			frm[15] = 8'h01;
		end
		c = 32'hFFFF_FFFF;
		foreach (frm[i]) begin
			c = c ^ {24'h0, frm[i]};
			for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
		end
		c = ~c ^ {31'h0, bad};
		for (int i = 0; i < 4; i++) frm.push_back(c[8*i +: 8]);
	endtask

	task automatic frame(input int n, input logic pse, bad, bpre, mii, input int ex);
		int n0;
		n0 = fe_count;
		nbytes = 0;
		build(n, pse, bad);
		phy.send(frm, bpre, mii);
		for (int k = 0; k < 40 && fe_count == n0; k++) @(posedge mclk);
		chk(fe_count - n0, ex, "frame end count");
		if (ex != 0 && fe_count == n0) final_report();
	endtask

	task copy(input logic ok, input logic pass);
		@(posedge mclk);
		copy_done <= 1'b1;
		copy_ok <= ok;
		filter_pass <= pass;
		@(posedge mclk);
		copy_done <= 1'b0;
	endtask

	task stat(input logic [4:0] e);
		chk({st.accepted, st.fcs_bad, st.pause, st.rx_err, st.preamble_bad}, e, "status");
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task t_regs;
		chk(ipg_bits, 32'h0000_0060, "reset gap");
		rdchk(`OFS_NET_CFG, 32'h0008_0000);
		rdchk(`OFS_PHY_SEL, 32'h0000_0000);
		rdchk(`OFS_CNT_256_511, 32'h0000_0000);
		rdchk(12'h100, 32'h0000_0000);
		wr(`OFS_NET_CFG, 32'hFFFF_FFFF);
		rdchk(`OFS_NET_CFG, 32'h77FF_F1FF);
		wr(`OFS_CNT_256_511, 32'h1234_5678);
		rdchk(`OFS_CNT_256_511, 32'h0000_0000);
		wr(`OFS_NET_CFG, CFG);
		wr(`OFS_PHY_SEL, 32'h0000_0001);
		rdchk(`OFS_PHY_SEL, 32'h0000_0001);
	endtask

	task automatic t_sizes;
		int sz[4] = '{252, 251, 507, 508};
		for (int i = 0; i < 4; i++) begin
			frame(sz[i], 0, 0, 0, 1, 1);
			chk(st.length, sz[i] + 4, "length");
			chk(nbytes, sz[i] + 4, "bytes");
			chk(lastb, frm[frm.size() - 1], "last byte");
			stat(5'b10000);
			copy(1'b1, 1'b1);
			cnt += (i % 2 == 0);
			rdchk(`OFS_CNT_256_511, cnt);
		end
	endtask

	task automatic t_copy;
		logic [2:0] ok = 3'b110, pass = 3'b101, pse = 3'b100;
		for (int i = 0; i < 3; i++) begin
			frame(296, pse[i], 0, 0, 1, 1);
			chk(st.pause, pse[i], "pause flag");
			copy(ok[i], pass[i]);
			rdchk(`OFS_CNT_256_511, cnt);
		end
	endtask

	task t_crc;
		frame(296, 0, 1, 0, 1, 1);
		stat(5'b01000);
		copy(1'b1, 1'b1);
		rdchk(`OFS_CNT_256_511, cnt);
		rd(`OFS_RX_STATUS, rv);
		chk(rv[1], 1, "fcs status");
		wr(`OFS_NET_CFG, CFG | 32'h0400_0000);
		frame(64, 0, 1, 0, 1, 1);
		stat(5'b11000);
		rdchk(`OFS_FCS_ERR_CNT, 32'h0000_0002);
		wr(`OFS_NET_CFG, CFG);
	endtask

	task t_pre;
		frame(64, 0, 0, 1, 1, 0);
		wr(`OFS_NET_CFG, CFG | 32'h2000_0000);
		frame(64, 0, 0, 1, 1, 1);
		stat(5'b10001);
		wr(`OFS_NET_CFG, CFG);
	endtask

	task t_hd;
		wr(`OFS_NET_CFG, 32'h0008_0000);
		tx_active <= 1'b1;
		frame(64, 0, 0, 0, 1, 0);
		wr(`OFS_NET_CFG, 32'h0208_0000);
		frame(64, 0, 0, 0, 1, 1);
		stat(5'b10000);
		tx_active <= 1'b0;
		wr(`OFS_NET_CFG, CFG);
	endtask

	task t_idle;
		wr(`OFS_NET_CFG, CFG | 32'h4000_0000);
		phy.idle_error();
		rd(`OFS_RX_STATUS, rv);
		chk(rv[0], 0, "idle error ignored");
		frame(64, 0, 0, 0, 1, 1);
		stat(5'b10000);
		wr(`OFS_NET_CFG, CFG);
		phy.idle_error();
		rd(`OFS_RX_STATUS, rv);
		chk(rv[0], 1, "idle error seen");
		wr(`OFS_RX_STATUS, 32'h0000_0001);
		rd(`OFS_RX_STATUS, rv);
		chk(rv[0], 0, "idle error cleared");
		frame(64, 0, 0, 0, 1, 1);
		chk(st.rx_err, 1, "marked frame");
	endtask

	task gap(input logic en, input logic [13:0] len, input logic [31:0] s, input int e);
		wr(`OFS_NET_CFG, CFG | {3'b000, en, 28'h0});
		wr(`OFS_GAP_STRETCH, s);
		@(posedge mclk);
		tx_frame_end <= 1'b1;
		tx_frame_len <= len;
		@(posedge mclk);
		tx_frame_end <= 1'b0;
		@(posedge mclk);
		#1 chk(ipg_bits, e, "gap");
	endtask

	task t_gap;
		gap(1'b0, 14'd100, 32'h0000_0002, 96);
		gap(1'b1, 14'd100, 32'h0000_0002, 200);
		gap(1'b1, 14'd10, 32'h0000_0002, 96);
		gap(1'b1, 14'd200, 32'h0000_0208, 400);
		gap(1'b1, 14'h3FFF, 32'h0000_00FF, 32'h0000_FFFF);
		wr(`OFS_NET_CFG, CFG);
	endtask

	task t_rmii;
		wr(`OFS_PHY_SEL, 32'h0000_0000);
		frame(296, 0, 0, 0, 0, 1);
		chk(st.length, 300, "rmii length");
		chk(lastb, frm[frm.size() - 1], "rmii last byte");
		copy(1'b1, 1'b1);
		cnt++;
		rdchk(`OFS_CNT_256_511, cnt);
	endtask

	initial begin
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		t_regs;
		t_sizes;
		t_copy;
		t_crc;
		t_pre;
		t_hd;
		t_idle;
		t_gap;
		t_rmii;
		final_report;
	end
endmodule // eth_mac_rx_config_stats_tb_top
`default_nettype wire

// ### tb/phy_link_model.sv
// Receive-side link partner model driving nibbles or dibits toward the MAC
`timescale 1ns/1ps
`default_nettype none

module phy_link_model (
	// Receive pins toward the MAC
	output var eth_mac_pkg::phy_rx_type phy_rx
);
	import eth_mac_pkg::*;

	initial phy_rx = '0;

	// ****************************************
	// Frame sender
	// ****************************************
	// Link clock stands still between frames; idle data shows the inverse
	task automatic send(input logic [7:0] q[$], input logic bad_pre, input logic mii);
		logic [7:0] s[$];
		logic [1:0] u;
		s = {8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'hD5};
		if (bad_pre) begin
			s[3] = 8'h5A;
		end
		s = {s, q};
		foreach (s[i]) begin
			for (int k = 0; k < (mii ? 2 : 4); k++) begin
				u = s[i][2*k +: 2];
				phy_rx.rxd = mii ? s[i][4*k +: 4] : {~u, u};
				phy_rx.dv = 1'b1;
				#100 phy_rx.clk = 1'b1;
				#100 phy_rx.clk = 1'b0;
			end
		end
		phy_rx.dv = 1'b0;
		phy_rx.rxd = ~phy_rx.rxd;
	endtask

	// Error flagged while no frame is on the wire
	task automatic idle_error();
		phy_rx.er = 1'b1;
		#200 phy_rx.er = 1'b0;
	endtask
endmodule // phy_link_model
`default_nettype wire
